// ---- logic/sdram_cap_core.sv ----
// Functional notes
// - A read to another bank ends a running auto-precharge write burst on the clock it is registered.
// - The interrupting read's first word appears the programmed read latency after the read is registered.
// - After an interrupting read the written bank precharges only once write recovery, counted from the read, is met.
// - On a read interruption the last stored word is the one registered a clock before the read; later inputs are ignored.
// - A write to another bank ends a running auto-precharge write burst on the clock it is registered.
// - After an interrupting write the old bank precharges only once write recovery, counted from the new write, is met.
// - On a write interruption the last word of the old bank is the one registered a clock before the new write.
// - A high chip select at the clock edge turns any command into a no-operation.
// - The mode register load is accepted whether it comes before or after the refresh cycles.
// - Address bits eight, nine and eleven are ignored on column commands.
// - An access with auto precharge closes its row by itself when the burst completes.
`include "sdram_cap_regs.svh"

module sdram_cap_core #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [1:0] ba,
   input wire logic [11:0] addr,
   input wire logic [15:0] dq_in,
   input wire logic dqm,
   output logic [15:0] dq_out,
   output logic dq_oe,
   output logic rd_req_valid,
   output logic [1:0] rd_req_bank,
   output logic [7:0] rd_req_col,
   input wire logic [15:0] rd_data,
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [1:0] wr_bank,
   output logic [7:0] wr_col,
   output logic [15:0] wr_data,
   output logic wbuf_full
);
   localparam logic [3:0] TWR_LOAD = 4'(`TWR_CYC);
   localparam logic [3:0] TRP_LOAD = 4'(`TRP_CYC);

   // ----------------------------------------
   // State
   // ----------------------------------------
   sdram_cap_pkg::bank_state_type bank_q [4];
   sdram_cap_pkg::bank_state_type bank_d [4];
   logic [3:0] tmr_q [4];
   logic [3:0] tmr_d [4];
   logic [2:0] bl_q, bl_d, cl_q, cl_d;
   logic wbs_q, wbs_d;
   logic bst_act_q, bst_act_d, bst_wr_q, bst_wr_d, bst_ap_q, bst_ap_d;
   logic [1:0] bst_bank_q, bst_bank_d;
   logic [7:0] bst_col_q, bst_col_d;
   logic [8:0] left_q, left_d;
   logic rd_req_q, rd_req_d;
   logic [1:0] rd_bank_q, rd_bank_d;
   logic [7:0] rd_col_q, rd_col_d;
   logic sh_vld_q, sh_vld_d;
   logic [15:0] sh_data_q, sh_data_d;
   logic oe_q, oe_d;
   logic [15:0] dq_q, dq_d;
   logic full_q, full_d;

   sdram_cap_pkg::cmd_type cmd;
   logic push;
   logic [25:0] push_word;
   logic fifo_in_ready;
   logic [25:0] fifo_out;
   logic [7:0] col;
   logic [8:0] burst_words;
   logic end_now;

   function automatic logic [8:0] bl_words(input logic [2:0] code);
      logic [8:0] w;
      w = (code == `FULL_PAGE_BL) ? 9'h100 : (9'h001 << code);
      return w;
   endfunction : bl_words

   // ----------------------------------------
   // Command and bank sequencing
   // ----------------------------------------
   always_comb begin
      // Deselect masks the command
      // chip select gate
      cmd = cs_n ? sdram_cap_pkg::CMD_NOP : sdram_cap_pkg::cmd_type'({ras_n, cas_n, we_n});
      col = addr[`COL_MSB:0];
      bl_d = bl_q;
      cl_d = cl_q;
      wbs_d = wbs_q;
      bst_act_d = bst_act_q;
      bst_wr_d = bst_wr_q;
      bst_ap_d = bst_ap_q;
      bst_bank_d = bst_bank_q;
      bst_col_d = bst_col_q;
      left_d = left_q;
      rd_req_d = 1'b0;
      rd_bank_d = rd_bank_q;
      rd_col_d = rd_col_q;
      push = 1'b0;
      push_word = {bst_bank_q, bst_col_q, dq_in};
      end_now = 1'b0;
      burst_words = bl_words(bl_q);
      for (int b = 0; b < 4; b++) begin
         bank_d[b] = bank_q[b];
         tmr_d[b] = tmr_q[b];
         if (tmr_q[b] > 4'h1) begin
            tmr_d[b] = tmr_q[b] - 4'h1;
         end else if (bank_q[b] == sdram_cap_pkg::BANK_RECOVER) begin
            bank_d[b] = sdram_cap_pkg::BANK_PRECH;
            tmr_d[b] = TRP_LOAD;
         end else if (bank_q[b] == sdram_cap_pkg::BANK_PRECH) begin
            bank_d[b] = sdram_cap_pkg::BANK_IDLE;
            tmr_d[b] = 4'h0;
         end
      end

      // Continue a running burst
      if (bst_act_q) begin
         if (bst_wr_q) begin
            push = !dqm;
         end else begin
            rd_req_d = 1'b1;
            rd_bank_d = bst_bank_q;
            rd_col_d = bst_col_q;
         end
         bst_col_d = bst_col_q + 8'h01;
         left_d = left_q - 9'h001;
         end_now = (left_q == 9'h001);
      end

      unique case (cmd)
         sdram_cap_pkg::CMD_READ, sdram_cap_pkg::CMD_WRITE: begin
            if (bank_q[ba] == sdram_cap_pkg::BANK_ACTIVE) begin
               // old burst stops here, this clock's data is the new command's
               // no word of the old burst pushed now
               push = 1'b0;
               rd_req_d = 1'b0;
               end_now = 1'b0;
               if (bst_act_q && bst_ap_q) begin
                  if (bst_wr_q) begin
                     bank_d[bst_bank_q] = sdram_cap_pkg::BANK_RECOVER;
                     tmr_d[bst_bank_q] = TWR_LOAD;
                  end else begin
                     bank_d[bst_bank_q] = sdram_cap_pkg::BANK_PRECH;
                     tmr_d[bst_bank_q] = TRP_LOAD;
                  end
               end
               bst_wr_d = (cmd == sdram_cap_pkg::CMD_WRITE);
               bst_ap_d = addr[`AP_BIT];
               bst_bank_d = ba;
               bst_col_d = col + 8'h01;
               if (cmd == sdram_cap_pkg::CMD_WRITE) begin
                  push = !dqm;
                  push_word = {ba, col, dq_in};
                  if (wbs_q) begin
                     burst_words = 9'h001;
                  end
               end else begin
                  rd_req_d = 1'b1;
                  rd_bank_d = ba;
                  rd_col_d = col;
               end
               left_d = burst_words - 9'h001;
               bst_act_d = (burst_words != 9'h001);
               if (burst_words == 9'h001 && addr[`AP_BIT]) begin
                  bank_d[ba] = (cmd == sdram_cap_pkg::CMD_WRITE) ? sdram_cap_pkg::BANK_RECOVER
                                                                 : sdram_cap_pkg::BANK_PRECH;
                  tmr_d[ba] = (cmd == sdram_cap_pkg::CMD_WRITE) ? TWR_LOAD : TRP_LOAD;
               end
            end
         end
         sdram_cap_pkg::CMD_ACT: begin
            if (bank_q[ba] == sdram_cap_pkg::BANK_IDLE) begin
               bank_d[ba] = sdram_cap_pkg::BANK_ACTIVE;
            end
         end
         sdram_cap_pkg::CMD_PRE: begin
            for (int b = 0; b < 4; b++) begin
               if ((addr[`AP_BIT] || ba == 2'(b)) && bank_q[b] == sdram_cap_pkg::BANK_ACTIVE) begin
                  bank_d[b] = sdram_cap_pkg::BANK_PRECH;
                  tmr_d[b] = TRP_LOAD;
               end
            end
            if (bst_act_q && (addr[`AP_BIT] || ba == bst_bank_q)) begin
               bst_act_d = 1'b0;
               push = 1'b0;
               rd_req_d = 1'b0;
            end
         end
         sdram_cap_pkg::CMD_BST: begin
            bst_act_d = 1'b0;
            push = 1'b0;
            rd_req_d = 1'b0;
         end
         sdram_cap_pkg::CMD_MRS: begin
            bl_d = addr[`MODE_BL_LSB +: 3];
            cl_d = addr[`MODE_CL_LSB +: 3];
            wbs_d = addr[`MODE_WBS_BIT];
         end
         sdram_cap_pkg::CMD_REF, sdram_cap_pkg::CMD_NOP: begin
         end
      endcase

      if (end_now) begin
         bst_act_d = 1'b0;
         if (bst_ap_q) begin
            bank_d[bst_bank_q] = bst_wr_q ? sdram_cap_pkg::BANK_RECOVER : sdram_cap_pkg::BANK_PRECH;
            tmr_d[bst_bank_q] = bst_wr_q ? TWR_LOAD : TRP_LOAD;
         end
      end
      // Words that find the buffer full are lost; wbuf_full warns the controller
      push = push && fifo_in_ready;
      full_d = !fifo_in_ready;
   end

   // ----------------------------------------
   // Read data latency
   // ----------------------------------------
   always_comb begin
      sh_vld_d = rd_req_q;
      sh_data_d = rd_data;
      // latency two taps the array directly, three via one stage
      if (cl_q == 3'h2) begin
         oe_d = rd_req_q;
         dq_d = rd_req_q ? rd_data : dq_q;
      end else begin
         oe_d = sh_vld_q;
         dq_d = sh_vld_q ? sh_data_q : dq_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         for (int b = 0; b < 4; b++) begin
            bank_q[b] <= sdram_cap_pkg::BANK_IDLE;
            tmr_q[b] <= 4'h0;
         end
         bl_q <= `RST_BL;
         cl_q <= `RST_CL;
         wbs_q <= 1'b0;
         bst_act_q <= 1'b0;
         bst_wr_q <= 1'b0;
         bst_ap_q <= 1'b0;
         bst_bank_q <= 2'h0;
         bst_col_q <= 8'h00;
         left_q <= 9'h000;
         rd_req_q <= 1'b0;
         rd_bank_q <= 2'h0;
         rd_col_q <= 8'h00;
         sh_vld_q <= 1'b0;
         sh_data_q <= 16'h0000;
         oe_q <= 1'b0;
         dq_q <= 16'h0000;
         full_q <= 1'b0;
      end else begin
         for (int b = 0; b < 4; b++) begin
            bank_q[b] <= bank_d[b];
            tmr_q[b] <= tmr_d[b];
         end
         bl_q <= bl_d;
         cl_q <= cl_d;
         wbs_q <= wbs_d;
         bst_act_q <= bst_act_d;
         bst_wr_q <= bst_wr_d;
         bst_ap_q <= bst_ap_d;
         bst_bank_q <= bst_bank_d;
         bst_col_q <= bst_col_d;
         left_q <= left_d;
         rd_req_q <= rd_req_d;
         rd_bank_q <= rd_bank_d;
         rd_col_q <= rd_col_d;
         sh_vld_q <= sh_vld_d;
         sh_data_q <= sh_data_d;
         oe_q <= oe_d;
         dq_q <= dq_d;
         full_q <= full_d;
      end
   end

   // ----------------------------------------
   // Write buffer toward the array
   // ----------------------------------------
   store_fifo #(.WIDTH(26), .DEPTH(FIFO_DEPTH)) u_store_fifo (
      .mclk(mclk),
      .rstn(rstn),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(push_word),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(fifo_out)
   );

   assign wr_bank = fifo_out[25:24];
   assign wr_col = fifo_out[23:16];
   assign wr_data = fifo_out[15:0];
   assign dq_out = dq_q;
   assign dq_oe = oe_q;
   assign rd_req_valid = rd_req_q;
   assign rd_req_bank = rd_bank_q;
   assign rd_req_col = rd_col_q;
   assign wbuf_full = full_q;
endmodule : sdram_cap_core

// ---- logic/sdram_cap_regs.svh ----
`ifndef SDRAM_CAP_REGS_SVH
`define SDRAM_CAP_REGS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_MHZ 40
`define TWR_NS 15
`define TRP_NS 20
// Least times round up, never below one cycle
`define TWR_CYC (((`TWR_NS * `CLK_MHZ + 999) / 1000) < 1 ? 1 : ((`TWR_NS * `CLK_MHZ + 999) / 1000))
`define TRP_CYC (((`TRP_NS * `CLK_MHZ + 999) / 1000) < 1 ? 1 : ((`TRP_NS * `CLK_MHZ + 999) / 1000))

// ----------------------------------------
// Address field positions
// ----------------------------------------
`define AP_BIT 10
`define COL_MSB 7
`define MODE_BL_LSB 0
`define MODE_CL_LSB 4
`define MODE_WBS_BIT 9

// ----------------------------------------
// Reset values and the full-page burst length code
// ----------------------------------------
`define RST_BL 3'h3
`define RST_CL 3'h2
`define FULL_PAGE_BL 3'h7

`endif

// ---- logic/sdram_cap_pkg.sv ----
package sdram_cap_pkg;

   // Gray order along idle, active, recovery, precharge
   typedef enum logic [1:0] {
      BANK_IDLE = 2'h0,
      BANK_ACTIVE = 2'h1,
      BANK_RECOVER = 2'h3,
      BANK_PRECH = 2'h2
   } bank_state_type;

   // Encoded as {ras_n, cas_n, we_n}
   typedef enum logic [2:0] {
      CMD_MRS = 3'h0,
      CMD_REF = 3'h1,
      CMD_PRE = 3'h2,
      CMD_ACT = 3'h3,
      CMD_WRITE = 3'h4,
      CMD_READ = 3'h5,
      CMD_BST = 3'h6,
      CMD_NOP = 3'h7
   } cmd_type;

endpackage : sdram_cap_pkg

// ---- logic/store_fifo.sv ----
module store_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
   logic [AW:0] count_q, count_d;
   logic out_valid_q, out_valid_d;
   logic [WIDTH-1:0] out_data_q, out_data_d;
   logic push, pop;

   // Output stage is a register so out_valid and out_data come from flops
   always_comb begin
      push = in_valid && (count_q != (AW + 1)'(DEPTH));
      pop = (count_q != '0) && (!out_valid_q || out_ready);
      wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
      rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
      count_d = count_q + (AW + 1)'(push) - (AW + 1)'(pop);
      out_valid_d = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid_q);
      out_data_d = pop ? mem_q[rd_ptr_q] : out_data_q;
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
         out_valid_q <= 1'b0;
         out_data_q <= '0;
      end else begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         count_q <= count_d;
         out_valid_q <= out_valid_d;
         out_data_q <= out_data_d;
      end
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   assign in_ready = (count_q != (AW + 1)'(DEPTH));
   assign out_valid = out_valid_q;
   assign out_data = out_data_q;
endmodule : store_fifo

// ---- verif/sdram_cap_chk.sv ----
module sdram_cap_chk (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [1:0] ba,
   input wire logic [11:0] addr,
   input wire logic dq_oe,
   input wire logic rd_req_valid,
   input wire logic [1:0] rd_req_bank,
   input wire logic [7:0] rd_req_col,
   input wire logic wr_valid,
   input wire logic wr_ready,
   input wire logic [15:0] wr_data,
   input wire logic wbuf_full
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   logic rd_cmd;
   assign rd_cmd = !cs_n && {ras_n, cas_n, we_n} == sdram_cap_pkg::CMD_READ;
   sequence rd_start;
      $rose(rd_req_valid);
   endsequence
   // Excludes a fresh read, which may restart the column count
   sequence burst_next;
      rd_req_valid && $past(rd_req_valid) && !$past(rd_cmd);
   endsequence
   rd_cmd_a: assert property (rd_start |-> $past({ras_n, cas_n, we_n}) == sdram_cap_pkg::CMD_READ)
      else $error("read request without read command");
   nop_read_a: assert property (rd_start |-> !$past(cs_n))
      else $error("read request from deselected command");
   col_sel_a: assert property (rd_start |-> rd_req_col == $past(addr[7:0]) && rd_req_bank == $past(ba))
      else $error("read column or bank differs from command");
   col_step_a: assert property (burst_next |-> rd_req_col == $past(rd_req_col) + 8'h01)
      else $error("read column does not step by one");
   rd_out_a: assert property (rd_req_valid |-> ##[1:2] dq_oe)
      else $error("read word not driven out");
   oe_cause_a: assert property ($rose(dq_oe) |-> $past(rd_req_valid) || $past(rd_req_valid, 2))
      else $error("read output without request");
   wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
      else $error("stored word dropped while stalled");
   full_valid_a: assert property (wbuf_full |-> wr_valid)
      else $error("full buffer shows no word");
endmodule : sdram_cap_chk

bind sdram_cap_core sdram_cap_chk i_chk (.mclk(mclk), .rstn(rstn), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
   .we_n(we_n), .ba(ba), .addr(addr), .dq_oe(dq_oe), .rd_req_valid(rd_req_valid), .rd_req_bank(rd_req_bank),
   .rd_req_col(rd_req_col), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wbuf_full(wbuf_full));

// ---- verif/array_model.sv ----
module array_model (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic stall,
   input wire logic rd_req_valid,
   input wire logic [1:0] rd_req_bank,
   input wire logic [7:0] rd_req_col,
   output logic [15:0] rd_data,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [1:0] wr_bank,
   input wire logic [7:0] wr_col,
   input wire logic [15:0] wr_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [25:0] got[$];
   logic [15:0] word;
   assign word = {rd_req_bank, 6'h2A, rd_req_col};
   // Inverse outside a request, so a mistimed sample cannot match
   assign rd_data = rd_req_valid ? word : ~word;
   assign wr_ready = ~stall;
   always @(posedge mclk) begin
      if (rstn && wr_valid && wr_ready) begin
         got.push_back({wr_bank, wr_col, wr_data});
      end
   end
endmodule : array_model

// ---- verif/testbench.sv ----
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic cs_n = 1'b1;
   logic ras_n = 1'b1;
   logic cas_n = 1'b1;
   logic we_n = 1'b1;
   logic dqm = 1'b0;
   logic stall = 1'b0;
   logic [1:0] ba = 2'h0;
   logic [11:0] addr = 12'h000;
   logic [15:0] dq_in = 16'h0000;
   logic [15:0] dq_out, rd_data, wr_data;
   logic [1:0] rd_req_bank, wr_bank;
   logic [7:0] rd_req_col, wr_col;
   logic dq_oe, rd_req_valid, wr_valid, wr_ready, wbuf_full;
   int checks = 0;
   int n_mismatch = 0;
   int cyc = 0;
   int t_cmd = 0;
   logic [31:0] seed = 32'h00000007;
   logic [31:0] rd_log[$];
   logic [25:0] exp_wr[$];
   always #12.5 mclk = ~mclk;
   sdram_cap_core #(.FIFO_DEPTH(16)) i_dut (.mclk(mclk), .rstn(rstn), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in), .dqm(dqm), .dq_out(dq_out), .dq_oe(dq_oe),
      .rd_req_valid(rd_req_valid), .rd_req_bank(rd_req_bank), .rd_req_col(rd_req_col), .rd_data(rd_data),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_bank(wr_bank), .wr_col(wr_col), .wr_data(wr_data),
      .wbuf_full(wbuf_full));
   array_model i_part (.mclk(mclk), .rstn(rstn), .stall(stall), .rd_req_valid(rd_req_valid),
      .rd_req_bank(rd_req_bank), .rd_req_col(rd_req_col), .rd_data(rd_data), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_bank(wr_bank), .wr_col(wr_col), .wr_data(wr_data));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction : rnd
   function logic [15:0] array_word(input logic [1:0] b, input logic [7:0] c);
      return {b, 6'h2A, c};
   endfunction : array_word
   task complete_run();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task cmd(input sdram_cap_pkg::cmd_type c, input logic [1:0] b, input logic [11:0] a, input logic [15:0] d,
         input logic sel_n);
      @(posedge mclk);
      {ras_n, cas_n, we_n} <= c;
      cs_n <= sel_n;
      ba <= b;
      addr <= a;
      dq_in <= d;
      t_cmd = cyc + 1;
   endtask : cmd
   task idle(input int n);
      repeat (n) cmd(sdram_cap_pkg::CMD_NOP, 2'h0, 12'h000, rnd(), 1'b1);
   endtask : idle
   // Seventeen words fit while the array stalls: sixteen buffered plus the output stage
   task wburst(input logic [1:0] b, input logic [7:0] c, input logic [3:0] hi, input int n);
      logic [15:0] d;
      for (int i = 0; i < n; i++) begin
         d = rnd();
         if (i == 0) cmd(sdram_cap_pkg::CMD_WRITE, b, {hi, c}, d, 1'b0);
         else cmd(sdram_cap_pkg::CMD_NOP, b, 12'h000, d, 1'b0);
         if (exp_wr.size() < 17) exp_wr.push_back({b, c + i[7:0], d});
      end
   endtask : wburst
   task chk_wr();
      chk("stored count", exp_wr.size(), i_part.got.size());
      while (exp_wr.size() > 0 && i_part.got.size() > 0) begin
         chk("stored word", exp_wr.pop_front(), i_part.got.pop_front());
      end
      exp_wr.delete();
      i_part.got.delete();
   endtask : chk_wr
   task chk_rd(input int t0, input logic [1:0] b, input logic [7:0] c);
      chk("read count", 8, rd_log.size());
      for (int i = 0; i < 8 && rd_log.size() > 0; i++) begin
         chk("read word", {t0[15:0] + i[15:0], array_word(b, c + i[7:0])}, rd_log.pop_front());
      end
      rd_log.delete();
   endtask : chk_rd
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (dq_oe === 1'b1) rd_log.push_back({cyc[15:0], dq_out});
      if (cyc == 2000) begin
         n_mismatch++;
         complete_run();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      logic [7:0] c;
      logic [7:0] c2;
      int rc;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      cmd(sdram_cap_pkg::CMD_MRS, 2'h0, 12'h023, 16'h0000, 1'b0);
      cmd(sdram_cap_pkg::CMD_REF, 2'h0, 12'h000, 16'h0000, 1'b0);
      idle(4);
      stall <= 1'b1;
      cmd(sdram_cap_pkg::CMD_ACT, 2'h0, 12'h000, 16'h0000, 1'b0);
      wburst(2'h0, 8'h00, 4'h0, 8);
      wburst(2'h0, 8'h08, 4'h0, 8);
      wburst(2'h0, 8'h10, 4'h0, 8);
      idle(9);
      chk("buffer full", 1'b1, wbuf_full);
      repeat (60) begin
         @(posedge mclk);
         c = 8'(rnd());
         stall <= c[0];
      end
      @(posedge mclk);
      stall <= 1'b0;
      idle(20);
      chk("buffer full", 1'b0, wbuf_full);
      chk_wr();
      cmd(sdram_cap_pkg::CMD_PRE, 2'h0, 12'h400, 16'h0000, 1'b0);
      idle(4);
      c = 8'(rnd());
      c2 = 8'(rnd());
      cmd(sdram_cap_pkg::CMD_ACT, 2'h0, 12'h123, 16'h0000, 1'b0);
      cmd(sdram_cap_pkg::CMD_ACT, 2'h1, 12'h0AB, 16'h0000, 1'b0);
      wburst(2'h0, c, 4'hF, 2);
      cmd(sdram_cap_pkg::CMD_READ, 2'h1, {4'hB, c2}, rnd(), 1'b0);
      rc = t_cmd;
      // Refused only while the old bank still recovers or precharges
      cmd(sdram_cap_pkg::CMD_ACT, 2'h0, 12'h123, rnd(), 1'b0);
      idle(12);
      chk_rd(rc + 2, 2'h1, c2);
      chk_wr();
      cmd(sdram_cap_pkg::CMD_READ, 2'h0, 12'h000, 16'h0000, 1'b0);
      idle(6);
      chk("refused read", 0, rd_log.size());
      cmd(sdram_cap_pkg::CMD_ACT, 2'h0, 12'h123, 16'h0000, 1'b0);
      cmd(sdram_cap_pkg::CMD_WRITE, 2'h0, {4'h0, c}, rnd(), 1'b1);
      cmd(sdram_cap_pkg::CMD_READ, 2'h0, {4'h0, c}, 16'h0000, 1'b1);
      idle(10);
      chk_wr();
      chk("deselected read", 0, rd_log.size());
      cmd(sdram_cap_pkg::CMD_READ, 2'h0, {4'h4, c}, 16'h0000, 1'b0);
      rc = t_cmd;
      idle(12);
      chk_rd(rc + 2, 2'h0, c);
      cmd(sdram_cap_pkg::CMD_ACT, 2'h2, 12'h055, 16'h0000, 1'b0);
      cmd(sdram_cap_pkg::CMD_ACT, 2'h3, 12'h0AA, 16'h0000, 1'b0);
      wburst(2'h2, c, 4'h4, 3);
      wburst(2'h3, c2, 4'h4, 8);
      idle(8);
      chk_wr();
      cmd(sdram_cap_pkg::CMD_READ, 2'h2, 12'h000, 16'h0000, 1'b0);
      cmd(sdram_cap_pkg::CMD_READ, 2'h3, 12'h000, 16'h0000, 1'b0);
      idle(8);
      chk("closed banks", 0, rd_log.size());
      // Latency three, loaded after the refresh this time
      cmd(sdram_cap_pkg::CMD_MRS, 2'h0, 12'h033, 16'h0000, 1'b0);
      cmd(sdram_cap_pkg::CMD_READ, 2'h1, {4'h0, c2}, 16'h0000, 1'b0);
      rc = t_cmd;
      idle(12);
      chk_rd(rc + 3, 2'h1, c2);
      // Masked second word, then a burst stop: only the first word is stored
      cmd(sdram_cap_pkg::CMD_WRITE, 2'h1, {4'h0, c}, 16'h1234, 1'b0);
      cmd(sdram_cap_pkg::CMD_NOP, 2'h1, 12'h000, 16'h5678, 1'b0);
      dqm <= 1'b1;
      cmd(sdram_cap_pkg::CMD_BST, 2'h1, 12'h000, 16'h9ABC, 1'b0);
      dqm <= 1'b0;
      idle(6);
      exp_wr.push_back({2'h1, c, 16'h1234});
      chk_wr();
      complete_run();
   end
endmodule : testbench
